// ### include/pcd_pkg.sv
package pcd_pkg;

   // Clock rate and detection interval.
   localparam int CLK_MHZ = 10;
   localparam int DET_TIME_US = 30;
   localparam int DET_CYCLES = DET_TIME_US * CLK_MHZ;
   localparam logic [8:0] DET_LAST = 9'(DET_CYCLES - 1);

   // Analog thresholds (millivolts) and sink current (microamps), kept for reference by the comparator front ends.
   localparam int RAMP_UVLO_MV = 4000;
   localparam int TIED_HIGH_MV = 4500;
   localparam int SINK_UA = 50;

   // Phase outputs: index 0 to 3 are main phases 1 to 4, index 4 is the auxiliary rail.
   localparam int N_PH = 5;
   localparam int AUX_IDX = 4;

   // Register byte addresses.
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_STAT = 4'h4;
   localparam logic [3:0] ADR_CFG = 4'h8;

   // Control register fields and reset value.
   localparam int CTRL_HOLD_BIT = 0;
   localparam logic CTRL_HOLD_RST = 1'b0;

   // Status register fields.
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_RAMP_OK_BIT = 8;
   localparam int STAT_VCC_OK_BIT = 9;
   localparam int STAT_DRV_FB_BIT = 10;
   localparam int STAT_EN_BIT = 11;

   // Configuration register fields.
   localparam int CFG_COUNT_LSB = 0;
   localparam int CFG_AUX_OFF_BIT = 4;
   localparam int CFG_TIED_LSB = 8;
   localparam int CFG_VALID_BIT = 15;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,
      ST_DETECT = 5'h02,
      ST_START  = 5'h04,
      ST_RUN    = 5'h08,
      ST_FAULT  = 5'h10
   } pcd_state_e;

endpackage : pcd_pkg

// ### include/pcd_pwm_if.sv
`timescale 1ns/1ps
interface pcd_pwm_if;
   logic [4:0] active;
   logic [4:0] req;
   logic run;
   logic hold_low;
   logic [4:0] pwm;
   logic [4:0] mid;
   logic [4:0] oe_n;

   modport ctl (output active, output req, output run, output hold_low,
                input pwm, input mid, input oe_n);
   modport stage (input active, input req, input run, input hold_low,
                  output pwm, output mid, output oe_n);
endinterface : pcd_pwm_if

// ### hdl/pcd_sync.sv
`timescale 1ns/1ps
module pcd_sync #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_r;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= '0;
         sync_o <= '0;
      end else begin
         meta_r <= async_i;
         sync_o <= meta_r;
      end
   end
endmodule : pcd_sync

// ### hdl/pcd_phase_out.sv
`timescale 1ns/1ps
module pcd_phase_out
   import pcd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   pcd_pwm_if.stage pif
);
   genvar g;
   generate
      for (g = 0; g < N_PH; g++) begin : g_ph
         logic left_mid_r;
         logic pwm_r;
         logic mid_r;
         logic oe_n_r;

         // An unused phase floats after detection; a live phase is driven low until run, then sits at mid level until its first pulse,
         // so in run a pre-charged output is not discharged through the low-side switch before that pulse.
         always_ff @(posedge clk_i) begin
            if (rst_i || pif.hold_low) begin
               left_mid_r <= 1'b0;
               pwm_r <= 1'b0;
               mid_r <= 1'b0;
               oe_n_r <= 1'b0;
            end else if (!pif.active[g]) begin
               left_mid_r <= 1'b0;
               pwm_r <= 1'b0;
               mid_r <= 1'b0;
               oe_n_r <= 1'b1;
            end else if (pif.run) begin
               left_mid_r <= left_mid_r | pif.req[g];
               pwm_r <= pif.req[g];
               mid_r <= ~(left_mid_r | pif.req[g]);
               oe_n_r <= 1'b0;
            end else begin
               left_mid_r <= 1'b0;
               pwm_r <= 1'b0;
               mid_r <= 1'b0;
               oe_n_r <= 1'b0;
            end
         end

         assign pif.pwm[g] = pwm_r;
         assign pif.mid[g] = mid_r;
         assign pif.oe_n[g] = oe_n_r;
      end
   endgenerate
endmodule : pcd_phase_out

// ### hdl/pcd_top.sv
`timescale 1ns/1ps
module pcd_top
   import pcd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   // Pins and comparator results, all asynchronous.
   input wire logic enable_i,
   input wire logic phase2_sense_return_i,
   input wire logic phase3_sense_return_i,
   input wire logic phase4_sense_return_i,
   input wire logic aux_rail_sense_return_i,
   input wire logic ramp_supply_sense_i,
   input wire logic vcc_ok_i,
   input wire logic gate_driver_on_i,
   // Modulator pulse requests on this clock: bits 0 to 3 main phases, bit 4 auxiliary.
   input wire logic [4:0] pwm_req_i,
   // Phase outputs, detection sinks, gate driver enable and soft start flag.
   output logic [4:0] pulse_out_o,
   output logic [4:0] pulse_mid_o,
   output logic [4:0] pulse_oe_n_o,
   output logic [2:0] sink_en_o,
   output logic gate_driver_on_o,
   output logic soft_start_o
);

   // Synchronised pin levels.
   logic [7:0] pins_s;
   wire en_s = pins_s[0];
   wire p2_hi_s = pins_s[1];
   wire p3_hi_s = pins_s[2];
   wire p4_hi_s = pins_s[3];
   wire aux_hi_s = pins_s[4];
   wire ramp_ok_s = pins_s[5];
   wire vcc_ok_s = pins_s[6];
   wire drv_fb_s = pins_s[7];

   pcd_sync #(.W(8)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i({gate_driver_on_i, vcc_ok_i, ramp_supply_sense_i, aux_rail_sense_return_i,
                phase4_sense_return_i, phase3_sense_return_i, phase2_sense_return_i,
                enable_i}),
      .sync_o(pins_s)
   );

   pcd_state_e state_r;
   pcd_state_e state_nxt;
   logic [8:0] det_cnt_r;
   logic [3:0] tied_r;
   logic cfg_valid_r;
   logic hold_r;
   logic drv_on_r;
   logic [2:0] sink_r;
   logic soft_r;
   logic ack_r;
   logic [31:0] rdat_r;

   // Supply good for switching: the ramp lockout only counts while enabled.
   wire ramp_uvlo = en_s & ~ramp_ok_s;
   wire supplies_ok = vcc_ok_s & ~ramp_uvlo;
   wire det_done = (state_r == ST_DETECT) && (det_cnt_r == DET_LAST);

   // Classification of pins 2, 3, 4 and the auxiliary pin, in that order.
   wire [3:0] tied_now = {aux_hi_s, p4_hi_s, p3_hi_s, p2_hi_s};

   // Active masks: phase 1 always runs, the others unless tied high.
   wire [3:0] main_active = {~tied_r[2], ~tied_r[1], ~tied_r[0], 1'b1};
   wire aux_active = ~tied_r[3];

   // Phase count follows the number of untied main pins.
   wire [2:0] phase_count = 3'h1 + 3'(main_active[1]) + 3'(main_active[2])
                            + 3'(main_active[3]);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (en_s) begin
               state_nxt = ST_DETECT;
            end
         end
         ST_DETECT: begin
            if (det_done) begin
               state_nxt = ST_START;
            end
         end
         ST_START: begin
            // Soft start only once supply, ramp and driver feedback all agree.
            if (supplies_ok && drv_on_r && drv_fb_s && !hold_r) begin
               state_nxt = ST_RUN;
            end else if (!supplies_ok) begin
               state_nxt = ST_FAULT;
            end
         end
         ST_RUN: begin
            if (!supplies_ok) begin
               state_nxt = ST_FAULT;
            end
         end
         ST_FAULT: begin
            if (supplies_ok) begin
               state_nxt = ST_START;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (!en_s) begin
         state_nxt = ST_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Detection interval counter.
   always_ff @(posedge clk_i) begin
      if (rst_i || state_r != ST_DETECT) begin
         det_cnt_r <= '0;
      end else begin
         det_cnt_r <= det_cnt_r + 9'h001;
      end
   end

   // The configuration is caught once and held, so a pin that drifts later
   // cannot change the phase count under load.
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_s) begin
         tied_r <= '0;
         cfg_valid_r <= 1'b0;
      end else if (det_done) begin
         tied_r <= tied_now;
         cfg_valid_r <= 1'b1;
      end
   end

   // Sinks are on only during detection, then removed from every pin.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sink_r <= '0;
      end else begin
         sink_r <= (state_nxt == ST_DETECT) ? 3'h7 : 3'h0;
      end
   end

   // Gate drivers are enabled once configured and supplies are good; a lockout drops them.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drv_on_r <= 1'b0;
         soft_r <= 1'b0;
      end else begin
         drv_on_r <= ((state_nxt == ST_START) || (state_nxt == ST_RUN)) && supplies_ok;
         soft_r <= (state_nxt == ST_RUN);
      end
   end

   // Phase output stage.
   pcd_pwm_if pif ();

   assign pif.active = {aux_active, main_active};
   assign pif.req = pwm_req_i;
   assign pif.run = (state_r == ST_RUN);
   assign pif.hold_low = (state_r == ST_IDLE) || (state_r == ST_DETECT);

   pcd_phase_out u_phase (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pif(pif)
   );

   assign pulse_out_o = pif.pwm;
   assign pulse_mid_o = pif.mid;
   assign pulse_oe_n_o = pif.oe_n;
   assign sink_en_o = sink_r;
   assign gate_driver_on_o = drv_on_r;
   assign soft_start_o = soft_r;

   // Register bus: one wait state, ack for one cycle, unmapped reads return zero.
   wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire sel_ctrl = (wb_adr_i == ADR_CTRL);
   wire sel_stat = (wb_adr_i == ADR_STAT);
   wire sel_cfg = (wb_adr_i == ADR_CFG);
   wire wr_ctrl = bus_req & wb_we_i & sel_ctrl & wb_sel_i[0];

   wire [31:0] stat_word = (32'(state_r) << STAT_STATE_LSB)
                         | (32'(ramp_ok_s) << STAT_RAMP_OK_BIT)
                         | (32'(vcc_ok_s) << STAT_VCC_OK_BIT)
                         | (32'(drv_fb_s) << STAT_DRV_FB_BIT)
                         | (32'(en_s) << STAT_EN_BIT);
   wire [31:0] cfg_word = (32'(cfg_valid_r ? phase_count : 3'h0) << CFG_COUNT_LSB)
                        | (32'(tied_r[3]) << CFG_AUX_OFF_BIT)
                        | (32'(tied_r) << CFG_TIED_LSB)
                        | (32'(cfg_valid_r) << CFG_VALID_BIT);
   wire [31:0] rd_mux = sel_ctrl ? (32'(hold_r) << CTRL_HOLD_BIT) :
                        sel_stat ? stat_word :
                        sel_cfg ? cfg_word : 32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdat_r <= '0;
         hold_r <= CTRL_HOLD_RST;
      end else begin
         ack_r <= bus_req;
         rdat_r <= (bus_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
         if (wr_ctrl) begin
            hold_r <= wb_dat_i[CTRL_HOLD_BIT];
         end
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

endmodule : pcd_top

// ### testbench/pcd_properties.sv
`timescale 1ns/1ps
module pcd_properties (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ramp_supply_sense_i,
   input wire logic gate_driver_on_i,
   input wire logic [4:0] pwm_req_i,
   input wire logic [4:0] pulse_out_o,
   input wire logic [4:0] pulse_mid_o,
   input wire logic [4:0] pulse_oe_n_o,
   input wire logic [2:0] sink_en_o,
   input wire logic gate_driver_on_o,
   input wire logic soft_start_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [8:0] sink_cnt_r;
   // Counts the cycles the sinks have been on, so the interval length can be judged.
   always_ff @(posedge clk_i) begin
      if (rst_i || !sink_en_o[0]) sink_cnt_r <= 9'h000;
      else sink_cnt_r <= sink_cnt_r + 9'h001;
   end
   det_sinks_a: assert property (
      sink_en_o != 3'h0 |-> sink_en_o == 3'h7 && !soft_start_o) else $error("sinks wrong");
   det_low_a: assert property (
      sink_en_o[0] |-> !pulse_out_o[0] && !pulse_oe_n_o[0]) else $error("phase 1 not low");
   sink_span_a: assert property (
      $fell(sink_en_o[0]) |-> sink_cnt_r == 9'h12C) else $error("detect length wrong");
   cfg_hold_a: assert property (
      soft_start_o && $past(soft_start_o) |-> $stable(pulse_oe_n_o)) else $error("cfg moved");
   tied_quiet_a: assert property (
      (pulse_oe_n_o & (pulse_out_o | pulse_mid_o)) == 5'h00) else $error("floated out active");
   mid_entry_a: assert property (
      $rose(soft_start_o) |-> ##[0:1] pulse_mid_o == ~pulse_oe_n_o) else $error("no mid");
   mid_exit_a: assert property (
      soft_start_o && $fell(pulse_mid_o[0]) |-> $past(pwm_req_i[0])) else $error("mid left");
   pulse_cause_a: assert property (
      (pulse_out_o & ~$past(pwm_req_i)) == 5'h00) else $error("pulse without request");
   ramp_lock_a: assert property (
      soft_start_o && !ramp_supply_sense_i |-> ##[1:5] !gate_driver_on_o) else $error("no lockout");
   run_gate_a: assert property (
      $rose(soft_start_o) |-> gate_driver_on_o && $past(gate_driver_on_i, 2))
      else $error("run without drivers");
endmodule : pcd_properties

bind pcd_top pcd_properties u_props (.clk_i(clk_i), .rst_i(rst_i),
   .ramp_supply_sense_i(ramp_supply_sense_i), .gate_driver_on_i(gate_driver_on_i),
   .pwm_req_i(pwm_req_i), .pulse_out_o(pulse_out_o), .pulse_mid_o(pulse_mid_o),
   .pulse_oe_n_o(pulse_oe_n_o), .sink_en_o(sink_en_o), .gate_driver_on_o(gate_driver_on_o),
   .soft_start_o(soft_start_o));

// ### testbench/pcd_drv_model.sv
`timescale 1ns/1ps
module pcd_drv_model (
   input wire logic clk_i,
   input wire logic [3:0] tied_i,
   input wire logic [2:0] sink_en_i,
   input wire logic drv_en_i,
   input wire logic slow_i,
   output logic [3:0] sense_o,
   output logic drv_fb_o
);
   int dly;
   // A pulled-up pin stays above 4.5 V; an untied pin sits at the low output level.
   assign sense_o = tied_i;
   // The slow driver answers late, so a restart must really wait for the readback.
   always_ff @(posedge clk_i) begin
      if (!drv_en_i) begin
         dly <= 0;
         drv_fb_o <= 1'b0;
      end else if (dly < (slow_i ? 20 : 1)) dly <= dly + 1;
      else drv_fb_o <= 1'b1;
   end
endmodule : pcd_drv_model

// ### testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin mismatches++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module testbench;
   import pcd_pkg::*;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, enable_i, ramp_r, slow_r;
   logic [3:0] wb_adr_i, tied_r, sense;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [4:0] pwm_req_i, pulse_out_o, pulse_mid_o, pulse_oe_n_o;
   logic [2:0] sink_en_o;
   logic drv_on, drv_fb, soft_start_o, vcc_r;
   logic [2:0] mains [4] = '{3'h0, 3'h4, 3'h5, 3'h7};
   int mismatches = 0;
   int n_tests = 0;
   pcd_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .enable_i(enable_i),
      .phase2_sense_return_i(sense[0]), .phase3_sense_return_i(sense[1]),
      .phase4_sense_return_i(sense[2]), .aux_rail_sense_return_i(sense[3]),
      .ramp_supply_sense_i(ramp_r), .vcc_ok_i(vcc_r), .gate_driver_on_i(drv_fb),
      .pwm_req_i(pwm_req_i), .pulse_out_o(pulse_out_o), .pulse_mid_o(pulse_mid_o),
      .pulse_oe_n_o(pulse_oe_n_o), .sink_en_o(sink_en_o), .gate_driver_on_o(drv_on),
      .soft_start_o(soft_start_o));
   pcd_drv_model u_drv (.clk_i(clk_i), .tied_i(tied_r), .sink_en_i(sink_en_o),
      .drv_en_i(drv_on), .slow_i(slow_r), .sense_o(sense), .drv_fb_o(drv_fb));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      #2000000;
      mismatches++;
      close_out();
   end
   task automatic close_out;
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      `CHK("ack", 1'b1, wb_ack_o)
   endtask : wb
   task automatic wait_ss(input int lim);
      int k;
      k = 0;
      while (soft_start_o !== 1'b1 && k < lim) begin
         @(posedge clk_i);
         k++;
      end
      @(posedge clk_i);
   endtask : wait_ss
   task automatic t_bus;
      wb(1'b1, 4'hC, 32'hFFFF_FFFF);
      wb(1'b0, 4'hC, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      wb(1'b1, ADR_CTRL, 32'h1);
      wb(1'b0, ADR_CTRL, 32'h0);
      `CHK("ctrl", 32'h1, rd)
      wb(1'b1, ADR_CTRL, 32'h0);
   endtask : t_bus
   task automatic t_det(input logic [3:0] t, input logic [2:0] n);
      int c;
      logic [4:0] oe;
      enable_i <= 1'b0;
      tied_r <= t;
      repeat (6) @(posedge clk_i);
      enable_i <= 1'b1;
      c = 0;
      repeat (10) if (sink_en_o !== 3'h7) @(posedge clk_i);
      while (sink_en_o === 3'h7 && c < 400) begin
         if ({pulse_out_o[0], pulse_oe_n_o[0]} === 2'b00) c++;
         @(posedge clk_i);
      end
      `CHK("detect span", 300, c)
      wait_ss(100);
      oe = {t, 1'b0};
      `CHK("float", oe, pulse_oe_n_o)
      `CHK("sinks off", 3'h0, sink_en_o)
      `CHK("mid", ~oe, pulse_mid_o)
      tied_r <= ~t;
      pwm_req_i <= 5'h1F;
      repeat (2) @(posedge clk_i);
      `CHK("overlap", ~oe, pulse_out_o)
      pwm_req_i <= 5'h00;
      repeat (8) @(posedge clk_i);
      wb(1'b0, ADR_CFG, 32'h0);
      `CHK("cfg", {16'h0, 4'h8, t, 3'h0, t[3], 1'b0, n}, rd)
   endtask : t_det
   task automatic t_ramp;
      enable_i <= 1'b0;
      ramp_r <= 1'b0;
      slow_r <= 1'b1;
      tied_r <= 4'h0;
      repeat (8) @(posedge clk_i);
      wb(1'b0, ADR_STAT, 32'h0);
      `CHK("idle", 5'h01, rd[4:0])
      ramp_r <= 1'b1;
      enable_i <= 1'b1;
      wait_ss(500);
      `CHK("run", 1'b1, soft_start_o)
      ramp_r <= 1'b0;
      repeat (8) @(posedge clk_i);
      `CHK("drv off", 1'b0, drv_on)
      wb(1'b0, ADR_STAT, 32'h0);
      `CHK("fault", 5'h10, rd[4:0])
      ramp_r <= 1'b1;
      repeat (12) @(posedge clk_i);
      `CHK("wait fb", 1'b0, soft_start_o)
      wait_ss(100);
      `CHK("restart", 1'b1, soft_start_o)
      // A supply loss in run must drop the drivers and restart only once it returns.
      vcc_r <= 1'b0;
      repeat (8) @(posedge clk_i);
      `CHK("vcc drv off", 1'b0, drv_on)
      `CHK("vcc stop", 1'b0, soft_start_o)
      vcc_r <= 1'b1;
      repeat (12) @(posedge clk_i);
      `CHK("vcc wait fb", 1'b0, soft_start_o)
      wait_ss(100);
      `CHK("vcc restart", 1'b1, soft_start_o)
   endtask : t_ramp
   initial begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, enable_i, slow_r} = 5'h00;
      ramp_r = 1'b1;
      vcc_r = 1'b1;
      wb_adr_i = 4'h0;
      wb_dat_i = 32'h0;
      tied_r = 4'h0;
      pwm_req_i = 5'h00;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_bus();
      for (int i = 0; i < 8; i++) t_det({i[2], mains[i % 4]}, 3'(4 - i % 4));
      t_ramp();
      close_out();
   end
endmodule : testbench
